// *** logic/tcf_irq_top.sv ***
// The register offsets and the AHB-Lite register port were left to the implementer.
module tcf_irq_top
    import tcf_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [1:0]                 hresp,
    output logic [31:0]                hrdata,
    input  wire tcf_events_t           ev,
    input  wire logic [NCH-1:0][LVLW-1:0] fifo_count,
    input  wire logic [NLIN-1:0]       linear_compare_done,
    input  wire logic [NCH-1:0]        pwm_level,
    input  wire logic [SWW-1:0]        card_index_switch,
    output logic [NCH-1:0]             pulse_gen_trigger,
    output logic [NCH-1:0]             trigger_out,
    output logic [NCH-1:0]             logic_out,
    output logic                       irq_req
);

    tcf_state_t q;
    tcf_state_t d;
    logic       acc;
    logic [NCH-1:0] pg_trig;
    logic [NCH-1:0] lvl_now;

    function automatic logic rising(input logic now, input logic prev);
        return now & ~prev;
    endfunction

    function automatic logic [31:0] rd_word(input tcf_state_t s, input logic [5:0] idx);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int i = 0; i <= NCH; i++) begin
            if (idx == IDX_MASK0 + 6'(i)) begin
                w[MW-1:0] = s.mask[i];
            end
            if (idx == IDX_PEND0 + 6'(i)) begin
                w[MW-1:0] = s.pend[i];
            end
        end
        for (int i = 0; i < NCH; i++) begin
            if (idx == IDX_THR0 + 6'(i)) begin
                w[LVLW-1:0] = s.thr[i];
            end
        end
        if (idx == IDX_TRGCFG) begin
            w[CFG_EN_LSB +: NCH]       = s.trg_en;
            w[CFG_POL_LSB +: NCH]      = s.trg_pol;
            w[CFG_MODE_LSB +: NCH]     = s.ttl_mode;
            w[CFG_LVL_LSB +: NCH]      = s.ttl_lvl;
            w[CFG_SRC_LSB +: NCH*NCH]  = s.trg_src;
        end
        if (idx == IDX_CARD) begin
            w[SWW-1:0] = s.sw2;
        end
        return w;
    endfunction

    assign acc = hsel & hready & (htrans == HTRANS_NONSEQ);

    assign pg_trig = ev.pulse_trig | q.man;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            lvl_now[c] = fifo_count[c] < q.thr[c];
        end
    end

    always_comb begin
        logic [NCH:0][MW-1:0] set;
        logic [NCH:0][MW-1:0] clr;
        logic [NCH-1:0]       hit;
        set = '0;
        clr = '0;
        hit = '0;
        d = q;
        d.sw1 = card_index_switch;
        d.sw2 = q.sw1;
        d.man = '0;
        d.dp_wr = acc & hwrite;
        d.dp_idx = (haddr[31:8] == 24'h00_0000) ? haddr[7:2] : IDX_NONE;
        if (acc && !hwrite) begin
            d.rdata = rd_word(q, d.dp_idx);
        end
        if (q.dp_wr) begin
            for (int i = 0; i <= NCH; i++) begin
                if (q.dp_idx == IDX_MASK0 + 6'(i)) begin
                    d.mask[i] = hwdata[MW-1:0];
                end
                if (q.dp_idx == IDX_PEND0 + 6'(i)) begin
                    clr[i] = hwdata[MW-1:0];
                end
            end
            for (int i = 0; i < NCH; i++) begin
                if (q.dp_idx == IDX_THR0 + 6'(i)) begin
                    d.thr[i] = hwdata[LVLW-1:0];
                end
            end
            if (q.dp_idx == IDX_TRGCFG) begin
                d.trg_en   = hwdata[CFG_EN_LSB +: NCH];
                d.trg_pol  = hwdata[CFG_POL_LSB +: NCH];
                d.ttl_mode = hwdata[CFG_MODE_LSB +: NCH];
                d.trg_src  = hwdata[CFG_SRC_LSB +: NCH*NCH];
                for (int c = 0; c < NCH; c++) begin
                    if (!d.ttl_mode[c]) begin
                        d.ttl_lvl[c] = hwdata[CFG_LVL_LSB + c];
                    end
                end
            end
            if (q.dp_idx == IDX_MANTRG) begin
                d.man = hwdata[NCH-1:0];
            end
        end
        for (int c = 0; c < NCH; c++) begin
            set[c][PULSE_OUTPUT_IRQ_BIT]      = pg_trig[c];
            set[c][FIFO_LOW_LEVEL_IRQ_BIT]    = rising(lvl_now[c], q.below[c]);
            set[c][FIFO_EMPTY_IRQ_BIT]        = rising(ev.fifo_empty[c], q.empty[c]);
            set[c][FIFO_FULL_IRQ_BIT]         = rising(ev.fifo_full[c], q.full[c]);
            set[c][POSITION_LATCH_IRQ_BIT]    = ev.position_latch_event[c];
            set[c][LOGIC_INPUT_TIMER_IRQ_BIT] = ev.timer_start[c];
        end
        set[LIN_CH] = linear_compare_done;
        d.irq = 1'b0;
        for (int i = 0; i <= NCH; i++) begin
            d.pend[i] = (q.pend[i] & ~clr[i]) | (set[i] & q.mask[i]);
            d.irq = d.irq | (|(d.pend[i] & d.mask[i]));
        end
        d.below = lvl_now;
        d.empty = ev.fifo_empty;
        d.full  = ev.fifo_full;
        d.pgt   = pg_trig;
        for (int c = 0; c < NCH; c++) begin
            hit[c] = |(pwm_level & q.trg_src[c]);
            d.trg_out[c] = q.trg_en[c] & (hit[c] ^ q.trg_pol[c]);
            d.ttl_out[c] = q.ttl_mode[c] ? d.trg_out[c] : q.ttl_lvl[c];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '{mask: {(NCH+1){MASK_RST}}, thr: {NCH{THR_RST}}, dp_idx: IDX_NONE,
                   default: '0};
        end else begin
            q <= d;
        end
    end

    // zero wait state: read data is fetched during the address phase
    assign hreadyout         = 1'b1;
    assign hresp             = HRESP_OKAY;
    assign hrdata            = q.rdata;
    assign pulse_gen_trigger = q.pgt;
    assign trigger_out       = q.trg_out;
    assign logic_out         = q.ttl_out;
    assign irq_req           = q.irq;

    logic pend_any;
    always_comb begin
        pend_any = 1'b0;
        for (int i = 0; i <= NCH; i++) begin
            pend_any = pend_any | (|(q.pend[i] & q.mask[i]));
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    irq_matches_pend_a: assert property (irq_req == pend_any)
        else $error("irq does not follow pending and mask");
    zero_mask_quiet_a: assert property ((q.mask == '0) |-> !irq_req)
        else $error("irq with all masks zero");
    pulse_sets_pend_a: assert property (
        (pg_trig[0] && q.mask[0][PULSE_OUTPUT_IRQ_BIT])
        |=> q.pend[0][PULSE_OUTPUT_IRQ_BIT] ##0 irq_req)
        else $error("pulse trigger not recorded");
    manual_reaches_gen_a: assert property (
        (q.dp_wr && q.dp_idx == IDX_MANTRG && hwdata[3]) |=> ##1 pulse_gen_trigger[3])
        else $error("manual trigger lost");
    level_edge_a: assert property (
        ($rose(lvl_now[1]) && q.mask[1][FIFO_LOW_LEVEL_IRQ_BIT])
        |=> q.pend[1][FIFO_LOW_LEVEL_IRQ_BIT])
        else $error("fifo level event lost");
    empty_edge_a: assert property (
        (q.empty[2] && ev.fifo_empty[2])
        |=> !$rose(q.pend[2][FIFO_EMPTY_IRQ_BIT]))
        else $error("empty fired without transition");
    linear_sets_a: assert property (
        (linear_compare_done[9] && q.mask[LIN_CH][9]) |=> q.pend[LIN_CH][9])
        else $error("linear done lost");
    masked_no_set_a: assert property (
        (!q.mask[3][POSITION_LATCH_IRQ_BIT] && !q.pend[3][POSITION_LATCH_IRQ_BIT])
        |=> !q.pend[3][POSITION_LATCH_IRQ_BIT])
        else $error("disabled factor went pending");
    ttl_copy_a: assert property (
        q.ttl_mode[0] |=> (logic_out[0] == trigger_out[0]))
        else $error("logic output not copying trigger");
    trg_off_a: assert property (!q.trg_en[1] |=> !trigger_out[1])
        else $error("disabled trigger output active");
    card_index_a: assert property (
        $stable(card_index_switch)[*4] |-> q.sw2 == card_index_switch)
        else $error("card index not synchronised");

    full_edge_a: assert property (
        ($rose(ev.fifo_full[3]) && q.mask[3][FIFO_FULL_IRQ_BIT])
        |=> q.pend[3][FIFO_FULL_IRQ_BIT])
        else $error("fifo full event lost");
    latch_sets_a: assert property (
        (ev.position_latch_event[0] && q.mask[0][POSITION_LATCH_IRQ_BIT])
        |=> q.pend[0][POSITION_LATCH_IRQ_BIT])
        else $error("latch event lost");
    timer_sets_a: assert property (
        (ev.timer_start[1] && q.mask[1][LOGIC_INPUT_TIMER_IRQ_BIT])
        |=> q.pend[1][LOGIC_INPUT_TIMER_IRQ_BIT])
        else $error("timer start event lost");
    linear_first_a: assert property (
        (linear_compare_done[0] && q.mask[LIN_CH][0]) |=> q.pend[LIN_CH][0])
        else $error("linear comparator zero lost");
    pend_clear_a: assert property (
        (q.dp_wr && q.dp_idx == IDX_PEND0 + 6'(3) && hwdata[0] && !pg_trig[3])
        |=> !q.pend[3][PULSE_OUTPUT_IRQ_BIT])
        else $error("pending bit not cleared");
    pend_hold_a: assert property (
        (q.pend[0][PULSE_OUTPUT_IRQ_BIT] && !(q.dp_wr && q.dp_idx == IDX_PEND0))
        |=> q.pend[0][PULSE_OUTPUT_IRQ_BIT])
        else $error("pending bit dropped without clear");
    mask_store_a: assert property (
        (q.dp_wr && q.dp_idx == IDX_MASK0) |=> (q.mask[0] == $past(hwdata[MW-1:0])))
        else $error("mask word not stored");
    trg_follow_a: assert property (
        (q.trg_en[0] && !q.trg_pol[0])
        |=> (trigger_out[0] == $past(|(pwm_level & q.trg_src[0]))))
        else $error("trigger output not following source");
    lvl_ignored_a: assert property (
        (q.dp_wr && q.dp_idx == IDX_TRGCFG && hwdata[CFG_MODE_LSB + 2])
        |=> (q.ttl_lvl[2] == $past(q.ttl_lvl[2])))
        else $error("level write taken in trigger mode");
    card_read_a: assert property (
        (acc && !hwrite && haddr[31:8] == 24'h00_0000 && haddr[7:2] == IDX_CARD)
        |=> (hrdata == {28'h000_0000, $past(q.sw2)}))
        else $error("card index read wrong");

    irq_seen_c: cover property ($rose(irq_req));
    clear_seen_c: cover property ($fell(irq_req));
    manual_c: cover property (q.dp_wr && q.dp_idx == IDX_MANTRG ##2 |pulse_gen_trigger);
    linear_c: cover property (|(q.pend[LIN_CH] & q.mask[LIN_CH]));
    level_c: cover property ($rose(q.pend[1][FIFO_LOW_LEVEL_IRQ_BIT]));

endmodule // tcf_irq_top

// *** logic/tcf_pkg.sv ***
package tcf_pkg;
    localparam int NCH   = 4;
    localparam int NLIN  = 10;
    localparam int MW    = 10;
    localparam int SWW   = 4;
    localparam int LVLW  = 10;
    // irq enable mask bit positions, channels 0..3
    localparam int PULSE_OUTPUT_IRQ_BIT      = 0;
    localparam int FIFO_LOW_LEVEL_IRQ_BIT    = 1;
    localparam int FIFO_EMPTY_IRQ_BIT        = 2;
    localparam int FIFO_FULL_IRQ_BIT         = 3;
    localparam int POSITION_LATCH_IRQ_BIT    = 4;
    localparam int LOGIC_INPUT_TIMER_IRQ_BIT = 5;
    localparam int LIN_CH                    = 4;
    // word indices (byte address = 4 * index)
    localparam logic [5:0] IDX_MASK0  = 6'h00;
    localparam logic [5:0] IDX_PEND0  = 6'h08;
    localparam logic [5:0] IDX_THR0   = 6'h10;
    localparam logic [5:0] IDX_TRGCFG = 6'h14;
    localparam logic [5:0] IDX_MANTRG = 6'h15;
    localparam logic [5:0] IDX_CARD   = 6'h16;
    localparam logic [5:0] IDX_NONE   = 6'h3f;
    // output routing register fields
    localparam int CFG_EN_LSB   = 0;
    localparam int CFG_POL_LSB  = 4;
    localparam int CFG_MODE_LSB = 8;
    localparam int CFG_LVL_LSB  = 12;
    localparam int CFG_SRC_LSB  = 16;
    localparam logic [MW-1:0]   MASK_RST = 10'h000;
    localparam logic [LVLW-1:0] THR_RST  = 10'h000;
    localparam logic [1:0]      HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]      HRESP_OKAY    = 2'h0;

    typedef logic [NCH-1:0] tcf_vec4_t;

    typedef struct packed {
        tcf_vec4_t pulse_trig;
        tcf_vec4_t fifo_empty;
        tcf_vec4_t fifo_full;
        tcf_vec4_t position_latch_event;
        tcf_vec4_t timer_start;
    } tcf_events_t;

    typedef struct packed {
        logic [NCH:0][MW-1:0]    mask;
        logic [NCH:0][MW-1:0]    pend;
        logic [NCH-1:0][LVLW-1:0] thr;
        tcf_vec4_t                trg_en;
        tcf_vec4_t                trg_pol;
        tcf_vec4_t                ttl_mode;
        tcf_vec4_t                ttl_lvl;
        logic [NCH-1:0][NCH-1:0]  trg_src;
        tcf_vec4_t                below;
        tcf_vec4_t                empty;
        tcf_vec4_t                full;
        logic [SWW-1:0]           sw1;
        logic [SWW-1:0]           sw2;
        tcf_vec4_t                man;
        tcf_vec4_t                pgt;
        tcf_vec4_t                trg_out;
        tcf_vec4_t                ttl_out;
        logic                     irq;
        logic                     dp_wr;
        logic [5:0]               dp_idx;
        logic [31:0]              rdata;
    } tcf_state_t;
endpackage

// *** test/tcf_event_src.sv ***
// far-side event sources: comparators, fifos, latch inputs, timers, linear units
module tcf_event_src
    import tcf_pkg::*;
(
    input  wire logic                hclk,
    output tcf_events_t              ev,
    output logic [NLIN-1:0]          lin_done,
    output logic [NCH-1:0][LVLW-1:0] fifo_count
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ev = '0;
        lin_done = '0;
        fifo_count = {NCH{10'h008}};
    end
    // one event of kind k on unit c, then every strobe drops and the fifo refills
    task automatic fire(input int k, input int c);
        @(posedge hclk);
        case (k)
            0: ev.pulse_trig[c] <= 1'b1;
            1: fifo_count[c] <= 10'h004;
            2: ev.fifo_empty[c] <= 1'b1;
            3: ev.fifo_full[c] <= 1'b1;
            4: ev.position_latch_event[c] <= 1'b1;
            5: ev.timer_start[c] <= 1'b1;
            default: lin_done[c] <= 1'b1;
        endcase
        @(posedge hclk);
        ev <= '0;
        lin_done <= '0;
        fifo_count <= {NCH{10'h008}};
    endtask
endmodule // tcf_event_src

// *** test/tb_trigger_card_interrupt_factors.sv ***
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_trigger_card_interrupt_factors;
    import tcf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, irq_req;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, hresp;
    logic [2:0]  hsize;
    logic [3:0]  pwm_level, card_index_switch, pulse_gen_trigger, trigger_out, logic_out;
    logic [NLIN-1:0]          lin_done;
    logic [NCH-1:0][LVLW-1:0] fifo_count;
    tcf_events_t ev;
    int          num_errors, checks_done;
    tcf_irq_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ev(ev), .fifo_count(fifo_count), .linear_compare_done(lin_done),
        .pwm_level(pwm_level), .card_index_switch(card_index_switch),
        .pulse_gen_trigger(pulse_gen_trigger), .trigger_out(trigger_out),
        .logic_out(logic_out), .irq_req(irq_req));
    tcf_event_src u_src (.hclk(hclk), .ev(ev), .lin_done(lin_done), .fifo_count(fifo_count));
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // the slave never stretches a phase (hreadyout is tied high); the bound only guards against a hang
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            final_report;
        end
    endtask
    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        `CHK(hresp, HRESP_OKAY)
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] v;
        ahb(a, 1'b1, d, v);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] v;
        ahb(a, 1'b0, 32'h0, v);
        `CHK(v, e)
    endtask
    task automatic t_regs;
        for (int i = 0; i <= LIN_CH; i++) rd(4 * i, 32'h0);
        for (int i = 0; i < NCH; i++) wr(4 * i, 32'h3f);
        wr(4 * LIN_CH, 32'h3ff);
        for (int i = 0; i <= LIN_CH; i++) rd(4 * i, (i == LIN_CH) ? 32'h3ff : 32'h3f);
        wr(32'h5c, 32'hffff_ffff);
        rd(32'h5c, 32'h0);
        rd(32'h100, 32'h0);
        rd(4 * IDX_CARD, 32'ha);
        for (int i = 0; i <= LIN_CH; i++) wr(4 * i, 32'h0);
    endtask
    task automatic t_factors;
        int c;
        for (int i = 0; i < NCH; i++) wr(4 * (IDX_THR0 + i), 32'h5);
        for (int k = 0; k < 6; k++) begin
            c = k % NCH;
            wr(4 * c, 32'h1 << k);
            u_src.fire(k, c);
            rd(4 * (IDX_PEND0 + c), 32'h1 << k);
            `CHK(irq_req, 1'b1)
            wr(4 * c, 32'h0);
            rd(4 * (IDX_PEND0 + c), 32'h1 << k);
            `CHK(irq_req, 1'b0)
            wr(4 * (IDX_PEND0 + c), 32'h1 << k);
            u_src.fire(k, c);
            rd(4 * (IDX_PEND0 + c), 32'h0);
        end
    endtask
    task automatic t_linear;
        for (int j = 0; j < NLIN; j += 9) begin
            wr(4 * LIN_CH, 32'h1 << j);
            u_src.fire(6, j);
            rd(4 * (IDX_PEND0 + LIN_CH), 32'h1 << j);
            `CHK(irq_req, 1'b1)
            wr(4 * (IDX_PEND0 + LIN_CH), 32'h1 << j);
            wr(4 * LIN_CH, 32'h0);
        end
    endtask
    task automatic t_manual;
        int hit;
        hit = 0;
        wr(4 * 3, 32'h1);
        wr(4 * IDX_MANTRG, 32'h8);
        repeat (4) begin
            @(negedge hclk);
            if (pulse_gen_trigger === 4'h8) hit++;
        end
        `CHK(hit, 1)
        rd(4 * (IDX_PEND0 + 3), 32'h1);
        rd(4 * IDX_MANTRG, 32'h0);
        wr(4 * (IDX_PEND0 + 3), 32'h1);
        wr(4 * 3, 32'h0);
    endtask
    task automatic t_route;
        @(posedge hclk);
        pwm_level <= 4'b0100;
        // ch2 is in copy mode, so its level bit must be ignored
        wr(4 * IDX_TRGCFG, 32'h0414_c423);
        repeat (3) @(negedge hclk);
        `CHK(trigger_out, 4'b0011)
        `CHK(logic_out, 4'b1000)
        @(posedge hclk);
        pwm_level <= 4'b0001;
        repeat (3) @(negedge hclk);
        `CHK(trigger_out, 4'b0000)
    endtask
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        final_report;
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, pwm_level} = '0;
        hsize = 3'h2;
        card_index_switch = 4'ha;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_factors();
        t_linear();
        t_manual();
        t_route();
        final_report();
    end
endmodule // tb_trigger_card_interrupt_factors
